// File: dv/swt_link_asserts.sv
// Concurrent checks on the shared single-wire line
`timescale 1ns/100ps
module swt_link_asserts #(
  parameter int unsigned RSTL_STD_CYC = 48000,
  parameter int unsigned RSTL_MIN_CYC = 4800,
  parameter int unsigned PROG_CYC = 1000000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Line drivers and resolved line
  input wire logic m_out,
  input wire logic m_oe,
  input wire logic d_out,
  input wire logic d_oe,
  input wire logic spu_en,
  input wire logic line
);
  logic [15:0] m_low_q, m_low_d, d_low_q, d_low_d, high_q, high_d, gap_q, gap_d;
  logic [15:0] pw_q, pw_d;
  logic [31:0] spu_q, spu_d;
  logic m_oe_q;

  function automatic logic [15:0] inc(input logic [15:0] v);
    return v + 16'(v != 16'hffff);
  endfunction : inc

  // Run lengths of each level, saturating at 16'hffff except the 32-bit spu_en count, which does not saturate
  always_comb begin
    m_low_d = m_oe ? inc(m_low_q) : 16'h0;
    d_low_d = d_oe ? inc(d_low_q) : 16'h0;
    high_d = line ? inc(high_q) : 16'h0;
    gap_d = (m_oe & ~m_oe_q) ? 16'h1 : inc(gap_q);
    spu_d = spu_en ? spu_q + 32'h1 : 32'h0;
    // Cycles from the end of a reset pulse until the presence pulse starts
    pw_d = (m_oe_q && !m_oe && m_low_q >= RSTL_MIN_CYC) ? 16'h1 : (pw_q != 16'h0 && !d_oe) ? inc(pw_q) : 16'h0;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      m_low_q <= 16'h0;
      d_low_q <= 16'h0;
      high_q <= 16'h0;
      gap_q <= 16'hffff;
      spu_q <= 32'h0;
      m_oe_q <= 1'b0;
      pw_q <= 16'h0;
    end else begin
      m_low_q <= m_low_d;
      d_low_q <= d_low_d;
      high_q <= high_d;
      gap_q <= gap_d;
      spu_q <= spu_d;
      m_oe_q <= m_oe;
      pw_q <= pw_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_OPEN_DRAIN: assert property ((m_oe |-> !m_out) and (d_oe |-> !d_out))
    else $error("line driven high by an end");
  AST_LOW_MIN: assert property ($fell(m_oe) |-> m_low_q >= 16'd100)
    else $error("master low pulse too short");
  AST_LOW_MAX: assert property ($fell(m_oe) |-> m_low_q <= RSTL_STD_CYC)
    else $error("master low pulse too long");
  AST_RECOVERY: assert property ($rose(m_oe) |-> high_q >= 16'd200)
    else $error("line recovery too short");
  AST_SLOT_GAP: assert property ($rose(m_oe) |-> gap_q >= 16'd800)
    else $error("slot shorter than minimum");
  AST_PRESENCE_WAIT: assert property ($rose(d_oe) && pw_q != 16'h0 |-> pw_q >= 16'h00c8)
    else $error("presence pulse too early");
  AST_PRESENCE_DUE: assert property (pw_q <= 16'h1770)
    else $error("presence pulse missing");
  AST_DEV_HOLD: assert property ($fell(d_oe) |-> d_low_q >= 16'd200)
    else $error("device low too short for sampling");
  AST_PROG_QUIET: assert property (spu_en |-> !m_oe && !d_oe)
    else $error("line pulled low during programming");
  AST_BYPASS_LEN: assert property ($fell(spu_en) |-> spu_q == PROG_CYC + 500)
    else $error("pullup bypass length wrong");

  cover property ($rose(spu_en));
  cover property ($rose(d_oe) && pw_q != 16'h0);
  cover property ($rose(d_oe) && pw_q == 16'h0);
  cover property ($fell(m_oe) && m_low_q >= RSTL_MIN_CYC && m_low_q < RSTL_STD_CYC);
endmodule : swt_link_asserts

// File: dv/testbench.sv
// Self-checking bench joining both ends of the single-wire link
`timescale 1ns/100ps
`include "swt_defines.svh"
module testbench;
  // Shortened timing shared by both ends and the checker
  localparam int unsigned W0L_CYC = 3100;
  localparam int unsigned SLOT_CYC = 3400;
  localparam int unsigned RSTL_CYC = 4000;
  localparam int unsigned RSTL_OD_CYC = 3200;
  localparam int unsigned MSP_CYC = 3300;
  localparam int unsigned RDET_CYC = 3500;
  localparam int unsigned PDL_CYC = 600;
  localparam int unsigned PROG_CYC = 2000;
  logic ref_clk, reset_n, cmd_valid, cmd_ready, rsp_valid, rsp_presence, m_od;
  logic rx_valid, tx_valid, tx_ready, reset_seen, d_od, prog_req, prog_busy, spu_at_busy;
  swt_pkg::swt_op_t cmd_op;
  logic [7:0] cmd_data, rsp_data, rx_data, tx_data, rx_last, wire_byte, rnd, code;
  logic [31:0] seed = 32'h743a;
  int num_errors = 0, check_count = 0, resets = 0, low_run = 0, busy_cnt = 0, cyc = 0;

  swt_if swt_if_i();
  swt_master #(.W0L_STD_CYC(W0L_CYC), .SLOT_STD_CYC(SLOT_CYC), .RSTL_STD_CYC(RSTL_CYC), .RSTL_OD_CYC(RSTL_OD_CYC),
    .MSP_STD_CYC(MSP_CYC), .PROG_CYC(PROG_CYC)) swt_master_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_presence(rsp_presence), .overdrive(m_od),
    .link(swt_if_i));
  swt_device #(.RDET_STD_CYC(RDET_CYC), .PDL_STD_CYC(PDL_CYC), .PROG_CYC(PROG_CYC)) swt_device_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .reset_seen(reset_seen), .overdrive(d_od),
    .prog_req(prog_req), .prog_busy(prog_busy), .link(swt_if_i));
  swt_link_asserts #(.RSTL_STD_CYC(RSTL_CYC), .RSTL_MIN_CYC(RSTL_OD_CYC), .PROG_CYC(PROG_CYC)) swt_link_asserts_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .m_out(swt_if_i.m_out), .m_oe(swt_if_i.m_oe),
    .d_out(swt_if_i.d_out), .d_oe(swt_if_i.d_oe), .spu_en(swt_if_i.spu_en), .line(swt_if_i.line));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic od_expect(input logic fresh, input logic [7:0] b);
    return fresh && (b === `SWT_OD_SKIP || b === `SWT_OD_MATCH);
  endfunction : od_expect

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic run_cmd(input swt_pkg::swt_op_t op, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
    check("rsp_valid", rsp_valid, 32'h1);
  endtask : run_cmd

  // Device side capture and a wire-level bit decoder, LSB first
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) rx_last = rx_data;
    if (reset_seen === 1'b1) resets++;
    if (prog_busy === 1'b1 && busy_cnt == 0) spu_at_busy = swt_if_i.spu_en;
    if (prog_busy === 1'b1) busy_cnt++;
    if (swt_if_i.line === 1'b0) begin
      low_run++;
    end else begin
      if (low_run > 0) wire_byte = {low_run < (m_od ? 200 : 2000), wire_byte[7:1]};
      low_run = 0;
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = swt_pkg::SWT_OP_RESET;
    cmd_data = 8'h00;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    prog_req = 1'b0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 2; i++) begin
      code = (i == 0) ? `SWT_OD_SKIP : `SWT_OD_MATCH;
      run_cmd(swt_pkg::SWT_OP_RESET_STD, 8'h00);
      check("presence", rsp_presence, 32'h1);
      check("reset_seen", resets, i + 1);
      check("rsp_rst", rsp_data, 32'h0);
      check("master_std", m_od, 32'h0);
      check("device_std", d_od, 32'h0);
      run_cmd(swt_pkg::SWT_OP_WRITE, code);
      check("rx_code", rx_last, code);
      check("rsp_wr", rsp_data, code);
      check("wire_code", wire_byte, code);
      check("master_od", m_od, od_expect(1'b1, code));
      check("device_od", d_od, od_expect(1'b1, code));
      seed = lfsr_next(seed);
      rnd = seed[7:0];
      if (i == 0) begin
        @(negedge ref_clk);
        tx_valid = 1'b1;
        tx_data = rnd;
        do @(posedge ref_clk); while (tx_ready !== 1'b1);
        @(negedge ref_clk);
        tx_valid = 1'b0;
        run_cmd(swt_pkg::SWT_OP_READ, 8'h00);
        check("rsp_read", rsp_data, rnd);
        check("wire_read", wire_byte, rnd);
        @(negedge ref_clk);
        prog_req = 1'b1;
        @(negedge ref_clk);
        prog_req = 1'b0;
        run_cmd(swt_pkg::SWT_OP_PROG, 8'h00);
        for (int n = 0; n < 1000 && prog_busy !== 1'b0; n++) @(negedge ref_clk);
        check("prog_len", busy_cnt, PROG_CYC);
        check("spu_at_busy", spu_at_busy, 32'h1);
      end else begin
        run_cmd(swt_pkg::SWT_OP_WRITE, rnd);
        check("rx_od", rx_last, rnd);
        check("wire_od", wire_byte, rnd);
        run_cmd(swt_pkg::SWT_OP_RESET, 8'h00);
        check("od_presence", rsp_presence, 32'h1);
        check("od_reset_seen", resets, 32'h3);
        check("od_master_kept", m_od, 32'h1);
        check("od_device_kept", d_od, 32'h1);
      end
      $display("test pass %0d done", i);
    end
    tally_and_finish();
  end
endmodule : testbench

// File: hw/swt_defines.svh
// Timing constants for the single-wire slot timing link
`ifndef SWT_DEFINES_SVH
`define SWT_DEFINES_SVH
`define SWT_CLK_NS 10
`define SWT_CYC_MIN(ns) (((ns) + `SWT_CLK_NS - 1) / `SWT_CLK_NS)
`define SWT_CYC_MAX(ns) ((ns) / `SWT_CLK_NS)
// Times in ns
`define SWT_W0L_STD_NS 60000
`define SWT_W0L_OD_NS 6000
`define SWT_W1L_STD_NS 6000
`define SWT_W1L_OD_NS 1000
`define SWT_RL_STD_NS 5000
`define SWT_RL_OD_NS 1000
`define SWT_MSR_STD_NS 13000
`define SWT_MSR_OD_NS 1500
`define SWT_SLOT_STD_NS 65000
`define SWT_SLOT_OD_NS 8000
`define SWT_REC_RST_NS 5000
`define SWT_RSTL_STD_NS 480000
`define SWT_RSTL_OD_NS 48000
`define SWT_MSP_STD_NS 70000
`define SWT_MSP_OD_NS 8000
`define SWT_PDH_STD_NS 30000
`define SWT_PDH_OD_NS 3000
`define SWT_PDL_STD_NS 120000
`define SWT_PDL_OD_NS 12000
`define SWT_REH_NS 2000
`define SWT_REH_MAX_NS 5000
`define SWT_WS_STD_NS 30000
`define SWT_WS_OD_NS 4000
`define SWT_HOLD_STD_NS 25000
`define SWT_HOLD_OD_NS 3000
`define SWT_RDET_STD_NS 300000
`define SWT_RDET_OD_NS 30000
`define SWT_PROG_NS 10000000
// Cycle counts
`define SWT_W0L_STD_CYC `SWT_CYC_MIN(`SWT_W0L_STD_NS)
`define SWT_W0L_OD_CYC `SWT_CYC_MIN(`SWT_W0L_OD_NS)
`define SWT_W1L_STD_CYC `SWT_CYC_MIN(`SWT_W1L_STD_NS)
`define SWT_W1L_OD_CYC `SWT_CYC_MIN(`SWT_W1L_OD_NS)
`define SWT_RL_STD_CYC `SWT_CYC_MIN(`SWT_RL_STD_NS)
`define SWT_RL_OD_CYC `SWT_CYC_MIN(`SWT_RL_OD_NS)
`define SWT_MSR_STD_CYC `SWT_CYC_MAX(`SWT_MSR_STD_NS)
`define SWT_MSR_OD_CYC `SWT_CYC_MAX(`SWT_MSR_OD_NS)
`define SWT_SLOT_STD_CYC `SWT_CYC_MIN(`SWT_SLOT_STD_NS)
`define SWT_SLOT_OD_CYC `SWT_CYC_MIN(`SWT_SLOT_OD_NS)
`define SWT_REC_RST_CYC `SWT_CYC_MIN(`SWT_REC_RST_NS)
`define SWT_RSTL_STD_CYC `SWT_CYC_MIN(`SWT_RSTL_STD_NS)
`define SWT_RSTL_OD_CYC `SWT_CYC_MIN(`SWT_RSTL_OD_NS)
`define SWT_MSP_STD_CYC `SWT_CYC_MIN(`SWT_MSP_STD_NS)
`define SWT_MSP_OD_CYC `SWT_CYC_MIN(`SWT_MSP_OD_NS)
`define SWT_PDH_STD_CYC `SWT_CYC_MIN(`SWT_PDH_STD_NS)
`define SWT_PDH_OD_CYC `SWT_CYC_MIN(`SWT_PDH_OD_NS)
`define SWT_PDL_STD_CYC `SWT_CYC_MIN(`SWT_PDL_STD_NS)
`define SWT_PDL_OD_CYC `SWT_CYC_MIN(`SWT_PDL_OD_NS)
`define SWT_REH_CYC `SWT_CYC_MIN(`SWT_REH_NS)
`define SWT_REH_MAX_CYC `SWT_CYC_MIN(`SWT_REH_MAX_NS)
`define SWT_WS_STD_CYC `SWT_CYC_MIN(`SWT_WS_STD_NS)
`define SWT_WS_OD_CYC `SWT_CYC_MIN(`SWT_WS_OD_NS)
`define SWT_HOLD_STD_CYC `SWT_CYC_MIN(`SWT_HOLD_STD_NS)
`define SWT_HOLD_OD_CYC `SWT_CYC_MIN(`SWT_HOLD_OD_NS)
`define SWT_RDET_STD_CYC `SWT_CYC_MIN(`SWT_RDET_STD_NS)
`define SWT_RDET_OD_CYC `SWT_CYC_MIN(`SWT_RDET_OD_NS)
`define SWT_PROG_CYC `SWT_CYC_MAX(`SWT_PROG_NS)
// Command bytes that switch both ends to overdrive
`define SWT_OD_SKIP 8'h3c
`define SWT_OD_MATCH 8'h69
`endif

// File: hw/swt_device.sv
// Tag end of the single-wire link: slots, presence, hold-off, programming
`timescale 1ns/100ps
`include "swt_defines.svh"
module swt_device #(
  parameter int unsigned RDET_STD_CYC = `SWT_RDET_STD_CYC,
  parameter int unsigned PDL_STD_CYC = `SWT_PDL_STD_CYC,
  parameter int unsigned PROG_CYC = `SWT_PROG_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Received bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Bytes to send on read slots
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Status and programming
  output logic reset_seen,
  output logic overdrive,
  input wire logic prog_req,
  output logic prog_busy,
  // Link
  swt_if.device link
);
  localparam int CW = 20;
  typedef enum logic [2:0] {D_IDLE, D_LOW, D_RST, D_PDH, D_PDL, D_HOLD} swt_dst_t;
  typedef enum logic [1:0] {P_OFF, P_ARM, P_REH, P_BUSY} swt_pst_t;
  swt_dst_t st_q, st_d;
  swt_pst_t pst_q, pst_d;
  logic [CW-1:0] cnt_q, cnt_d, pcnt_q, pcnt_d;
  logic [CW-1:0] ws_len, hold_len, rdet_len, pdh_len, pdl_len;
  logic od_q, od_d, first_q, first_d, oe_q, oe_d, rv_q, rv_d, rs_q, rs_d, bitv;
  logic [7:0] rxsh_q, rxsh_d, rd_q, rd_d, txsh_q, txsh_d;
  logic [2:0] rxn_q, rxn_d;
  logic [3:0] txn_q, txn_d;

  always_comb begin
    ws_len = od_q ? CW'(`SWT_WS_OD_CYC) : CW'(`SWT_WS_STD_CYC);
    hold_len = od_q ? CW'(`SWT_HOLD_OD_CYC) : CW'(`SWT_HOLD_STD_CYC);
    rdet_len = od_q ? CW'(`SWT_RDET_OD_CYC) : CW'(RDET_STD_CYC);
    pdh_len = od_q ? CW'(`SWT_PDH_OD_CYC) : CW'(`SWT_PDH_STD_CYC);
    pdl_len = od_q ? CW'(`SWT_PDL_OD_CYC) : CW'(PDL_STD_CYC);
  end

  assign tx_ready = (txn_q == 4'h0) && ((st_q == D_IDLE) || (st_q == D_HOLD));

  // Slot, reset and presence machine
  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q == {CW{1'b1}}) ? cnt_q : cnt_q + 1'b1;
    od_d = od_q;
    first_d = first_q;
    rxsh_d = rxsh_q;
    rxn_d = rxn_q;
    rd_d = rd_q;
    txsh_d = txsh_q;
    txn_d = txn_q;
    rv_d = 1'b0;
    rs_d = 1'b0;
    bitv = cnt_q < ws_len; // [RULE14]
    if (tx_valid && tx_ready) begin
      txsh_d = tx_data;
      txn_d = 4'h8;
    end
    case (st_q)
      D_IDLE: begin
        cnt_d = '0;
        if (!link.line) st_d = D_LOW;
      end
      D_LOW: begin
        if (link.line) begin
          st_d = D_HOLD;
          cnt_d = '0;
          if (txn_q != 4'h0) begin
            txsh_d = {1'b0, txsh_q[7:1]}; // [RULE13]
            txn_d = txn_q - 4'h1;
          end else begin
            rxsh_d = {bitv, rxsh_q[7:1]}; // [RULE13]
            rxn_d = rxn_q + 3'h1;
            if (rxn_q == 3'h7) begin
              rv_d = 1'b1;
              rd_d = rxsh_d;
              first_d = 1'b0;
              if (first_q && !od_q && (rxsh_d == `SWT_OD_SKIP || rxsh_d == `SWT_OD_MATCH)) od_d = 1'b1; // [RULE12]
            end
          end
        end else if (cnt_q >= rdet_len - 1'b1) begin
          st_d = D_RST;
        end
      end
      D_RST: begin
        if (link.line) begin
          if (cnt_q >= CW'(RDET_STD_CYC - 1)) od_d = 1'b0;
          st_d = D_PDH;
          cnt_d = '0;
          first_d = 1'b1;
          rxn_d = 3'h0;
          txn_d = 4'h0;
          rs_d = 1'b1;
        end
      end
      D_PDH: begin
        if (cnt_q >= pdh_len - 1'b1) begin // [RULE6]
          st_d = D_PDL;
          cnt_d = '0;
        end
      end
      D_PDL: begin
        if (cnt_q >= pdl_len - 1'b1) begin // [RULE6]
          st_d = D_HOLD;
          cnt_d = '0;
        end
      end
      D_HOLD: begin
        if (od_q || cnt_q >= CW'(`SWT_REH_CYC - 1)) st_d = D_IDLE; // [RULE7]
      end
      default: st_d = D_IDLE;
    endcase
    oe_d = (st_d == D_PDL) || ((st_d == D_LOW) && (txn_d != 4'h0) && !txsh_d[0] && (cnt_d < hold_len)); // [RULE4]
  end

  // Self-timed programming after the last rising edge
  always_comb begin
    pst_d = pst_q;
    pcnt_d = pcnt_q + 1'b1;
    case (pst_q)
      P_OFF: begin
        pcnt_d = '0;
        if (prog_req) pst_d = P_ARM;
      end
      P_ARM: begin
        pcnt_d = '0;
        if (link.line && (st_q != D_LOW)) pst_d = P_REH;
      end
      P_REH: begin
        if (pcnt_q >= CW'(`SWT_REH_MAX_CYC - 1)) begin // [RULE8]
          pst_d = P_BUSY;
          pcnt_d = '0;
        end
      end
      P_BUSY: begin
        if (pcnt_q >= CW'(PROG_CYC - 1)) pst_d = P_OFF; // [RULE8]
      end
      default: pst_d = P_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= D_IDLE;
      cnt_q <= '0;
      od_q <= 1'b0;
      first_q <= 1'b0;
      rxsh_q <= 8'h00;
      rxn_q <= 3'h0;
      rd_q <= 8'h00;
      txsh_q <= 8'h00;
      txn_q <= 4'h0;
      rv_q <= 1'b0;
      rs_q <= 1'b0;
      oe_q <= 1'b0;
      pst_q <= P_OFF;
      pcnt_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      od_q <= od_d;
      first_q <= first_d;
      rxsh_q <= rxsh_d;
      rxn_q <= rxn_d;
      rd_q <= rd_d;
      txsh_q <= txsh_d;
      txn_q <= txn_d;
      rv_q <= rv_d;
      rs_q <= rs_d;
      oe_q <= oe_d;
      pst_q <= pst_d;
      pcnt_q <= pcnt_d;
    end
  end

  assign rx_valid = rv_q;
  assign rx_data = rd_q;
  assign reset_seen = rs_q;
  assign overdrive = od_q;
  assign prog_busy = (pst_q == P_BUSY);
  assign link.d_out = 1'b0;
  assign link.d_oe = oe_q;
endmodule : swt_device

// File: hw/swt_if.sv
// Shared open-drain line between the bus master and the tag
`timescale 1ns/100ps
interface swt_if;
  logic m_out;
  logic m_oe;
  logic d_out;
  logic d_oe;
  logic spu_en;
  logic line;
  // Wired-AND of both drivers over the pullup
  assign line = ~((m_oe & ~m_out) | (d_oe & ~d_out));
  modport master (output m_out, output m_oe, output spu_en, input line);
  modport device (output d_out, output d_oe, input spu_en, input line);
endinterface : swt_if

// File: hw/swt_master.sv
// Bus master end of the single-wire link: reset, byte slots, programming wait
// Overview of operation
// RULE1: Write zero holds line low long enough
// RULE2: Write one is a short low pulse
// RULE3: Read slot starts with short low pulse
// RULE4: Device holds zero; master samples before limit
// RULE5: Each slot lasts at least minimum duration
// RULE6: Presence pulse follows reset after wait
// RULE7: Device ignores falls during rising-edge hold-off; in overdrive D_HOLD returns to D_IDLE after one cycle, with no hold-off
// RULE8: Programming cycle of 10 ms after copy
// RULE9: Master bypasses pullup during programming
// RULE10: Reset pulse held low within limits
// RULE11: Line recovers high between slots
// RULE12: Overdrive command byte switches both to overdrive
// RULE13: Bytes travel least significant bit first
// RULE14: Device samples written bit at fixed point
`timescale 1ns/100ps
`include "swt_defines.svh"
module swt_master #(
  parameter int unsigned W0L_STD_CYC = `SWT_W0L_STD_CYC,
  parameter int unsigned SLOT_STD_CYC = `SWT_SLOT_STD_CYC,
  parameter int unsigned RSTL_STD_CYC = `SWT_RSTL_STD_CYC,
  parameter int unsigned RSTL_OD_CYC = `SWT_RSTL_OD_CYC,
  parameter int unsigned MSP_STD_CYC = `SWT_MSP_STD_CYC,
  parameter int unsigned PROG_CYC = `SWT_PROG_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire swt_pkg::swt_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  // Response
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_presence,
  output logic overdrive,
  // Link
  swt_if.master link
);
  localparam int CW = 20;
  typedef enum logic [2:0] {M_IDLE, M_PRE, M_RLOW, M_RHIGH, M_SLOT, M_PROG} swt_mst_t;
  swt_mst_t st_q, st_d;
  swt_pkg::swt_op_t op_q, op_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [CW-1:0] w0_len, w1_len, rl_len, msr_len, slot_len, rstl_len, msp_len, lo_len;
  logic [7:0] sh_q, sh_d, rd_q, rd_d;
  logic [2:0] bit_q, bit_d;
  logic od_q, od_d, first_q, first_d, pres_q, pres_d;
  logic rv_q, rv_d, oe_q, oe_d, spu_q, spu_d;

  // Speed-dependent lengths
  always_comb begin
    w0_len = od_q ? CW'(`SWT_W0L_OD_CYC) : CW'(W0L_STD_CYC);
    w1_len = od_q ? CW'(`SWT_W1L_OD_CYC) : CW'(`SWT_W1L_STD_CYC);
    rl_len = od_q ? CW'(`SWT_RL_OD_CYC) : CW'(`SWT_RL_STD_CYC);
    msr_len = od_q ? CW'(`SWT_MSR_OD_CYC) : CW'(`SWT_MSR_STD_CYC);
    slot_len = od_q ? CW'(`SWT_SLOT_OD_CYC) : CW'(SLOT_STD_CYC);
    rstl_len = od_q ? CW'(RSTL_OD_CYC) : CW'(RSTL_STD_CYC);
    msp_len = od_q ? CW'(`SWT_MSP_OD_CYC) : CW'(MSP_STD_CYC);
  end

  assign cmd_ready = (st_q == M_IDLE);

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    cnt_d = cnt_q + 1'b1;
    sh_d = sh_q;
    rd_d = rd_q;
    bit_d = bit_q;
    od_d = od_q;
    first_d = first_q;
    pres_d = pres_q;
    spu_d = spu_q;
    rv_d = 1'b0;
    case (st_q)
      M_IDLE: begin
        cnt_d = '0;
        if (cmd_valid) begin
          op_d = cmd_op;
          sh_d = cmd_data;
          bit_d = 3'h0;
          case (cmd_op)
            swt_pkg::SWT_OP_RESET: st_d = M_PRE;
            swt_pkg::SWT_OP_RESET_STD: begin
              st_d = M_PRE;
              od_d = 1'b0;
            end
            swt_pkg::SWT_OP_WRITE: begin
              st_d = M_SLOT;
              rd_d = cmd_data;
            end
            swt_pkg::SWT_OP_READ: st_d = M_SLOT;
            swt_pkg::SWT_OP_PROG: begin
              st_d = M_PROG;
              spu_d = 1'b1; // [RULE9]
            end
            default: st_d = M_IDLE;
          endcase
        end
      end
      M_PRE: begin
        if (cnt_q >= CW'(`SWT_REC_RST_CYC - 1)) begin // [RULE11]
          st_d = M_RLOW;
          cnt_d = '0;
        end
      end
      M_RLOW: begin
        if (cnt_q >= rstl_len - 1'b1) begin // [RULE10]
          st_d = M_RHIGH;
          cnt_d = '0;
        end
      end
      M_RHIGH: begin
        if (cnt_q == msp_len) pres_d = !link.line; // [RULE6]
        if (cnt_q >= rstl_len - 1'b1) begin
          st_d = M_IDLE;
          rv_d = 1'b1;
          rd_d = 8'h00;
          first_d = 1'b1;
        end
      end
      M_SLOT: begin
        if (op_q == swt_pkg::SWT_OP_READ && cnt_q == msr_len) begin
          sh_d = {link.line, sh_q[7:1]}; // [RULE4] [RULE13]
        end
        if (cnt_q >= slot_len - 1'b1) begin // [RULE5] [RULE11]
          cnt_d = '0;
          bit_d = bit_q + 3'h1;
          if (op_q == swt_pkg::SWT_OP_WRITE) sh_d = {1'b0, sh_q[7:1]}; // [RULE13]
          if (bit_q == 3'h7) begin
            st_d = M_IDLE;
            rv_d = 1'b1;
            first_d = 1'b0;
            if (op_q == swt_pkg::SWT_OP_READ) begin
              rd_d = sh_q;
            end else if (first_q && !od_q && (rd_q == `SWT_OD_SKIP || rd_q == `SWT_OD_MATCH)) begin
              od_d = 1'b1; // [RULE12]
            end
          end
        end
      end
      M_PROG: begin
        if (cnt_q >= CW'(PROG_CYC + `SWT_REH_MAX_CYC - 1)) begin // [RULE8]
          st_d = M_IDLE;
          spu_d = 1'b0; // [RULE9]
          rv_d = 1'b1;
        end
      end
      default: st_d = M_IDLE;
    endcase
    // Low time of the coming slot
    if (op_d == swt_pkg::SWT_OP_READ) begin
      lo_len = rl_len; // [RULE3]
    end else if (sh_d[0]) begin
      lo_len = w1_len; // [RULE2]
    end else begin
      lo_len = w0_len; // [RULE1]
    end
    oe_d = (st_d == M_RLOW) || ((st_d == M_SLOT) && (cnt_d < lo_len));
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= M_IDLE;
      op_q <= swt_pkg::SWT_OP_RESET;
      cnt_q <= '0;
      sh_q <= 8'h00;
      rd_q <= 8'h00;
      bit_q <= 3'h0;
      od_q <= 1'b0;
      first_q <= 1'b0;
      pres_q <= 1'b0;
      rv_q <= 1'b0;
      oe_q <= 1'b0;
      spu_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      bit_q <= bit_d;
      od_q <= od_d;
      first_q <= first_d;
      pres_q <= pres_d;
      rv_q <= rv_d;
      oe_q <= oe_d;
      spu_q <= spu_d;
    end
  end

  assign rsp_valid = rv_q;
  assign rsp_data = rd_q;
  assign rsp_presence = pres_q;
  assign overdrive = od_q;
  assign link.m_out = 1'b0;
  assign link.m_oe = oe_q;
  assign link.spu_en = spu_q;
endmodule : swt_master

// File: hw/swt_pkg.sv
// Command types shared by the bus master end and the testbench of the single-wire link
package swt_pkg;
  typedef enum logic [2:0] {
    SWT_OP_RESET,
    SWT_OP_RESET_STD,
    SWT_OP_WRITE,
    SWT_OP_READ,
    SWT_OP_PROG
  } swt_op_t;
endpackage : swt_pkg
